// >>> design/spa_alarm_checker.v
// Protection alarm checker of the servo amplifier, with register port.
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "spa_consts.vh"

module spa_alarm_checker
#(
	parameter REGEN_WINDOW_CYC = `SPA_REGEN_WINDOW_CYC,
	parameter CW = 16
)
(
	// Clock and reset
	input  wire        REF_CLK_IN,
	input  wire        SYS_RST_IN,
	// Register port
	input  wire [7:0]  ADDR_IN,
	input  wire [31:0] WR_DATA_IN,
	input  wire        WR_IN,
	input  wire        RD_IN,
	output reg  [31:0] RD_DATA_OUT,
	// Host link commands
	input  wire        SERVO_ON_IN,
	input  wire        ATTR_C_VALID_IN,
	input  wire        ALARM_CLEAR_IN,
	input  wire        SOFT_RESET_IN,
	input  wire [7:0]  HOMING_TYPE_IN,
	input  wire        HOME_DETECT_IN,
	input  wire        HOME_RETURN_DONE_IN,
	input  wire        HOMING_CANCEL_IN,
	// Initialisation triggers
	input  wire        ABS_MODE_IN,
	input  wire        ATTR_C_ENABLE_DONE_IN,
	input  wire        MULTITURN_CLEAR_IN,
	input  wire        TOOL_OP_DONE_IN,
	// Position data
	input  wire [63:0] ABS_POS_IN,
	input  wire [63:0] GEAR_RATIO_IN,
	input  wire [63:0] DEV_PULSE_IN,
	input  wire [63:0] DEV_CMD_IN,
	input  wire        REGEN_PULSE_IN,
	// Alarm output
	output reg         ALARM_OUT,
	output reg  [7:0]  ALARM_MAIN_OUT,
	output reg  [7:0]  ALARM_SUB_OUT
);

	// ============================================================
	// Registers
	reg  [CW-1:0]    regen_output_limit_setup;
	reg  [23:0]      out_map;
	reg  [8*24-1:0]  in_map;
	reg              pwr_init;
	reg              homing_armed;
	reg  [CW-1:0]    regen_cnt;
	reg  [31:0]      win_cnt;
	reg  [CW:0]      next_regen;
	wire [6:0]       pin_err;
	wire             wr_cmd;
	wire             do_clear;
	wire             do_soft;
	wire             pin_apply;
	wire             init_evt;
	wire             win_end;
	wire             type_ok;
	reg              det_27;
	reg              det_28;
	reg              det_291;
	reg              det_292;
	reg              det_any;
	reg  [7:0]       det_main;
	reg  [7:0]       det_sub;
	integer          k;
	integer          j;

	// ============================================================
	// Helpers
	function fits32;
		input [63:0] v;
		begin
			fits32 = (v[63:31] == 33'h000000000) ||
				(v[63:31] == 33'h1FFFFFFFF);
		end
	endfunction

	function reached;
		input [63:0] v;
		input [63:0] lim;
		begin
			reached = ($signed(v) >= $signed(lim)) ||
				($signed(v) <= -$signed(lim));
		end
	endfunction

	// Input map slots sit one word apart above the base offset.
	function [7:0] in_addr;
		input [7:0] n;
		begin
			in_addr = `SPA_REG_INPUT_BASE + {n[5:0], 2'b00};
		end
	endfunction

	// ============================================================
	// Pin assignment check
	spa_pin_check
	#(
		.NIN       (8)
	)
	u_pin
	(
		.in_map_in (in_map),
		.out_map_in(out_map),
		.err_out   (pin_err)
	);

	// ============================================================
	// Command decode
	assign wr_cmd = WR_IN && (ADDR_IN == `SPA_REG_CMD);
	assign do_clear = ALARM_CLEAR_IN ||
		(wr_cmd && WR_DATA_IN[`SPA_CMD_CLEAR]);
	assign do_soft = SOFT_RESET_IN ||
		(wr_cmd && WR_DATA_IN[`SPA_CMD_SOFT_RESET]);
	assign pin_apply = wr_cmd && WR_DATA_IN[`SPA_CMD_PIN_APPLY];
	assign init_evt = pwr_init || ATTR_C_ENABLE_DONE_IN ||
		MULTITURN_CLEAR_IN || TOOL_OP_DONE_IN || pin_apply;
	assign type_ok = (HOMING_TYPE_IN >= `SPA_HOMING_TYPE_LO) &&
		(HOMING_TYPE_IN <= `SPA_HOMING_TYPE_HI);
	assign win_end = (win_cnt == REGEN_WINDOW_CYC - 1);

	// ============================================================
	// Register writes
	always @(posedge REF_CLK_IN or posedge SYS_RST_IN)
	begin
		if (SYS_RST_IN)
		begin
			regen_output_limit_setup <= `SPA_REGEN_LIMIT_RST;
			out_map <= `SPA_OUTPUT_MAP_RST;
			in_map <= {`SPA_INPUT_RST, `SPA_INPUT7_RST,
				`SPA_INPUT6_RST, `SPA_INPUT5_RST,
				`SPA_INPUT_RST, `SPA_INPUT_RST,
				`SPA_INPUT_RST, `SPA_INPUT_RST};
		end
		else if (WR_IN)
		begin
			if (ADDR_IN == `SPA_REG_REGEN_LIMIT)
				regen_output_limit_setup <= WR_DATA_IN[CW-1:0];
			if (ADDR_IN == `SPA_REG_OUTPUT_MAP)
				out_map <= WR_DATA_IN[23:0];
			for (k = 0; k < 8; k = k + 1)
				if (ADDR_IN == in_addr(k[7:0]))
					in_map[k*24 +: 24] <= WR_DATA_IN[23:0];
		end
	end

	// ============================================================
	// Register reads
	always @(posedge REF_CLK_IN or posedge SYS_RST_IN)
	begin
		if (SYS_RST_IN)
			RD_DATA_OUT <= 32'h00000000;
		else if (RD_IN)
		begin
			RD_DATA_OUT <= 32'h00000000;
			case (ADDR_IN)
				`SPA_REG_STATUS:
					RD_DATA_OUT <= {15'h0000, ALARM_OUT,
						ALARM_MAIN_OUT, ALARM_SUB_OUT};
				`SPA_REG_REGEN_LIMIT:
					RD_DATA_OUT[CW-1:0] <= regen_output_limit_setup;
				`SPA_REG_OUTPUT_MAP:
					RD_DATA_OUT[23:0] <= out_map;
				default:
					for (j = 0; j < 8; j = j + 1)
						if (ADDR_IN == in_addr(j[7:0]))
							RD_DATA_OUT[23:0] <= in_map[j*24 +: 24];
			endcase
		end
		else
			RD_DATA_OUT <= 32'h00000000;
	end

	// ============================================================
	// Power-up initialisation and homing tracking
	// The power-up check is raised one edge after release, so the
	// absolute-mode strap is sampled by the clock, not by the reset.
	always @(posedge REF_CLK_IN or posedge SYS_RST_IN)
	begin
		if (SYS_RST_IN)
		begin
			pwr_init <= 1'b1;
			homing_armed <= 1'b0;
		end
		else
		begin
			pwr_init <= 1'b0;
			if (HOME_RETURN_DONE_IN || HOMING_CANCEL_IN || do_soft)
				homing_armed <= 1'b0;
			else if (HOME_DETECT_IN && type_ok)
				homing_armed <= 1'b1;
		end
	end

	// ============================================================
	// Regenerated pulse rate window
	// One window counts pulses; the limit is pulses per window.
	always @*
	begin
		next_regen = {1'b0, regen_cnt} + {{CW{1'b0}}, REGEN_PULSE_IN};
	end

	always @(posedge REF_CLK_IN or posedge SYS_RST_IN)
	begin
		if (SYS_RST_IN)
		begin
			win_cnt <= 32'h00000000;
			regen_cnt <= {CW{1'b0}};
		end
		else
		begin
			if (win_end)
			begin
				win_cnt <= 32'h00000000;
				regen_cnt <= {CW{1'b0}};
			end
			else
			begin
				win_cnt <= win_cnt + 32'h00000001;
				if (!next_regen[CW])
					regen_cnt <= next_regen[CW-1:0];
			end
		end
	end

	// ============================================================
	// Detection and priority
	always @*
	begin
		det_27 = (SERVO_ON_IN && ATTR_C_VALID_IN) ||
			(HOMING_CANCEL_IN && homing_armed);
		det_28 = (regen_output_limit_setup != {CW{1'b0}}) &&
			(next_regen[CW] ||
			next_regen[CW-1:0] > regen_output_limit_setup);
		det_291 = init_evt && (ABS_MODE_IN || !pwr_init) &&
			(!fits32(ABS_POS_IN) ||
			GEAR_RATIO_IN[63:32] != 32'h00000000);
		det_292 = reached(DEV_PULSE_IN, `SPA_DEV_PULSE_LIM) ||
			reached(DEV_CMD_IN, `SPA_DEV_CMD_LIM + 64'h1);
		det_any = 1'b1;
		det_main = `SPA_MAIN_PIN;
		det_sub = 8'h00;
		if (det_27)
		begin
			det_main = `SPA_MAIN_POS_INIT;
			det_sub = `SPA_SUB_POS_INIT;
		end
		else if (det_291)
		begin
			det_main = `SPA_MAIN_OVF;
			det_sub = `SPA_SUB_OVF_POS;
		end
		else if (det_292)
		begin
			det_main = `SPA_MAIN_OVF;
			det_sub = `SPA_SUB_OVF_DEV;
		end
		else if (init_evt && pin_err[0])
			det_sub = 8'h00;
		else if (init_evt && pin_err[1])
			det_sub = 8'h01;
		else if (init_evt && pin_err[2])
			det_sub = 8'h02;
		else if (init_evt && pin_err[3])
			det_sub = 8'h03;
		else if (init_evt && pin_err[4])
			det_sub = 8'h04;
		else if (init_evt && pin_err[5])
			det_sub = 8'h05;
		else if (init_evt && pin_err[6])
			det_sub = `SPA_SUB_LATCH;
		else if (det_28)
		begin
			det_main = `SPA_MAIN_REGEN;
			det_sub = `SPA_SUB_REGEN;
		end
		else
			det_any = 1'b0;
	end

	// ============================================================
	// Alarm latch
	// A detection in the same cycle as a clear wins, so no alarm is
	// lost; a later alarm never overwrites the first one held.
	always @(posedge REF_CLK_IN or posedge SYS_RST_IN)
	begin
		if (SYS_RST_IN)
		begin
			ALARM_OUT <= 1'b0;
			ALARM_MAIN_OUT <= 8'h00;
			ALARM_SUB_OUT <= 8'h00;
		end
		else if (ALARM_OUT && !do_soft &&
			!(do_clear && ALARM_MAIN_OUT == `SPA_MAIN_REGEN))
		begin
			ALARM_OUT <= 1'b1;
		end
		else if (det_any)
		begin
			ALARM_OUT <= 1'b1;
			ALARM_MAIN_OUT <= det_main;
			ALARM_SUB_OUT <= det_sub;
		end
		else
		begin
			ALARM_OUT <= 1'b0;
			ALARM_MAIN_OUT <= 8'h00;
			ALARM_SUB_OUT <= 8'h00;
		end
	end

endmodule // spa_alarm_checker
`default_nettype wire

// >>> common/spa_consts.vh
// Constants of the servo protection alarm checker.
//
// ============================================================
// Overview of operation
// - Servo-on during attribute-C validation raises 27.7.
// - Homing cancel after home detect in homing types 17-29 raises 27.7.
// - Regenerated pulse rate over limit raises 28.0.
// - Regen limit zero disables the rate check.
// - Position or gear over 32 bits raises 29.1.
// - Initialisation runs at the listed trigger points.
// - Pulse deviation at 1073741823 or beyond raises 29.2.
// - Command deviation beyond 1073741824 raises 29.2.
// - Duplicate function on inputs 1-4 raises 33.0.
// - Duplicate function on inputs 5-8 raises 33.1.
// - Bad function or logic raises 33.2/33.3.
// - Undefined function on output 1 raises 33.4.
// - Undefined function on outputs 2-3 raises 33.5.
// - Latch inputs must sit on inputs 5-7.
// - Home or limit on latch pins raises 33.8.
// - Required latch function unassigned on inputs 5-7 raises 33.8.
// - Only soft reset clears 27.7, 29.x, 33.x.
`ifndef SPA_CONSTS_VH
`define SPA_CONSTS_VH

// ============================================================
// Register offsets
`define SPA_REG_STATUS      8'h00
`define SPA_REG_CMD         8'h04
`define SPA_REG_REGEN_LIMIT 8'h08
`define SPA_REG_OUTPUT_MAP  8'h0C
`define SPA_REG_INPUT_BASE  8'h10
`define SPA_REG_INPUT_LAST  8'h2C

// ============================================================
// Field positions
`define SPA_CMD_CLEAR       0
`define SPA_CMD_SOFT_RESET  1
`define SPA_CMD_PIN_APPLY   2
`define SPA_STAT_ACTIVE     16

// ============================================================
// Alarm codes
`define SPA_MAIN_POS_INIT   8'h1B
`define SPA_SUB_POS_INIT    8'h07
`define SPA_MAIN_REGEN      8'h1C
`define SPA_SUB_REGEN       8'h00
`define SPA_MAIN_OVF        8'h1D
`define SPA_SUB_OVF_POS     8'h01
`define SPA_SUB_OVF_DEV     8'h02
`define SPA_MAIN_PIN        8'h21
`define SPA_SUB_LATCH       8'h08

// ============================================================
// Function numbers and limits
`define SPA_FN_NONE         6'h00
`define SPA_FN_POS_LIMIT    6'h01
`define SPA_FN_NEG_LIMIT    6'h02
`define SPA_FN_HOME         6'h03
`define SPA_FN_LATCH1       6'h04
`define SPA_FN_LATCH2       6'h05
`define SPA_FN_LATCH3       6'h06
`define SPA_IN_FN_MAX       6'h1F
`define SPA_OUT_FN_MAX      6'h13
`define SPA_LOGIC_MAX       2'h1
`define SPA_HOMING_TYPE_LO  8'h11
`define SPA_HOMING_TYPE_HI  8'h1D
`define SPA_DEV_PULSE_LIM   64'h000000003FFFFFFF
`define SPA_DEV_CMD_LIM     64'h0000000040000000

// ============================================================
// Reset values
`define SPA_REGEN_LIMIT_RST 16'h0000
`define SPA_OUTPUT_MAP_RST  24'h000000
`define SPA_INPUT_RST       24'h000000
`define SPA_INPUT5_RST      24'h000404
`define SPA_INPUT6_RST      24'h000505
`define SPA_INPUT7_RST      24'h000606

// ============================================================
// Timing
`define SPA_CLK_PERIOD_NS   40
`define SPA_REGEN_WINDOW_NS 1000000
`define SPA_REGEN_WINDOW_CYC (`SPA_REGEN_WINDOW_NS / `SPA_CLK_PERIOD_NS)

`endif

// >>> design/spa_pin_check.v
// Pin function assignment checker for inputs, outputs and latch pins.
`timescale 1ns/10ps
`default_nettype none
`include "spa_consts.vh"

module spa_pin_check
#(
	parameter NIN = 8
)
(
	// Assignment maps
	input  wire [NIN*24-1:0] in_map_in,
	input  wire [23:0]       out_map_in,
	// Error flags: dup lo, dup hi, fn lo, fn hi, out1, out23, latch
	output reg  [6:0]        err_out
);

	integer i;
	integer m;
	reg [7:0] code;
	reg [5:0] fn;

	// ============================================================
	// Helpers
	function in_bad;
		input [7:0] c;
		begin
			in_bad = (c[5:0] > `SPA_IN_FN_MAX) || (c[7:6] > `SPA_LOGIC_MAX);
		end
	endfunction

	function is_latch;
		input [5:0] f;
		begin
			is_latch = (f == `SPA_FN_LATCH1) || (f == `SPA_FN_LATCH2) ||
				(f == `SPA_FN_LATCH3);
		end
	endfunction

	// ============================================================
	// Checks
	always @*
	begin
		err_out = 7'h00;
		code = 8'h00;
		fn = 6'h00;
		for (i = 0; i < NIN; i = i + 1)
		begin
			if (in_map_in[i*24+16 +: 6] != `SPA_FN_NONE)
			begin
				if (i < 4)
					err_out[0] = 1'b1;
				else
					err_out[1] = 1'b1;
			end
			for (m = 0; m < 2; m = m + 1)
			begin
				code = in_map_in[i*24+m*8 +: 8];
				fn = code[5:0];
				if (in_bad(code))
				begin
					if (i < 4)
						err_out[2] = 1'b1;
					else
						err_out[3] = 1'b1;
				end
				if (i == 4 && fn != `SPA_FN_LATCH1)
					err_out[6] = 1'b1;
				if (i == 5 && fn != `SPA_FN_LATCH2)
					err_out[6] = 1'b1;
				if (i == 6 && fn != `SPA_FN_LATCH3)
					err_out[6] = 1'b1;
				if ((i < 4 || i > 6) && is_latch(fn))
					err_out[6] = 1'b1;
				if (i >= 4 && i <= 6 && fn == `SPA_FN_NONE)
					err_out[6] = 1'b1;
				if (fn == `SPA_FN_HOME && (i == 5 || i == 6))
					err_out[6] = 1'b1;
				if (fn == `SPA_FN_POS_LIMIT && (i == 4 || i == 6))
					err_out[6] = 1'b1;
				if (fn == `SPA_FN_NEG_LIMIT && (i == 4 || i == 5))
					err_out[6] = 1'b1;
			end
		end
		if (out_map_in[5:0] > `SPA_OUT_FN_MAX)
			err_out[4] = 1'b1;
		if (out_map_in[13:8] > `SPA_OUT_FN_MAX ||
			out_map_in[21:16] > `SPA_OUT_FN_MAX)
			err_out[5] = 1'b1;
	end

endmodule // spa_pin_check
`default_nettype wire

// >>> test/spa_chk.sv
// Assertion checker of the servo protection alarm checker.
`timescale 1ns/10ps
`default_nettype none
module spa_chk
(
	// Clock, reset and register port
	input wire logic        REF_CLK_IN,
	input wire logic        SYS_RST_IN,
	input wire logic [7:0]  ADDR_IN,
	input wire logic        WR_IN,
	input wire logic        RD_IN,
	input wire logic [31:0] RD_DATA_OUT,
	// Host link and triggers
	input wire logic        SERVO_ON_IN,
	input wire logic        ATTR_C_VALID_IN,
	input wire logic        ALARM_CLEAR_IN,
	input wire logic        SOFT_RESET_IN,
	input wire logic [7:0]  HOMING_TYPE_IN,
	input wire logic        HOME_DETECT_IN,
	input wire logic        HOME_RETURN_DONE_IN,
	input wire logic        HOMING_CANCEL_IN,
	input wire logic        ATTR_C_ENABLE_DONE_IN,
	input wire logic        MULTITURN_CLEAR_IN,
	input wire logic        TOOL_OP_DONE_IN,
	input wire logic [63:0] DEV_PULSE_IN,
	input wire logic [63:0] DEV_CMD_IN,
	// Alarm output
	input wire logic        ALARM_OUT,
	input wire logic [7:0]  ALARM_MAIN_OUT,
	input wire logic [7:0]  ALARM_SUB_OUT
);
	// ==========
	// Helpers
	logic up;
	wire [16:0] code = {ALARM_OUT, ALARM_MAIN_OUT, ALARM_SUB_OUT};
	// Register writes may carry a soft reset, so they mask the checks.
	wire quiet = !SOFT_RESET_IN && !WR_IN && !ALARM_OUT;
	// The power-up edge may latch a higher-priority overflow alarm.
	wire idle = quiet && up && !SERVO_ON_IN && !HOMING_CANCEL_IN &&
		!ATTR_C_ENABLE_DONE_IN && !MULTITURN_CLEAR_IN && !TOOL_OP_DONE_IN;
	wire signed [63:0] dp = DEV_PULSE_IN;
	wire signed [63:0] dc = DEV_CMD_IN;
	always @(posedge REF_CLK_IN or posedge SYS_RST_IN)
	begin
		if (SYS_RST_IN)
			up <= 1'b0;
		else
			up <= 1'b1;
	end
	default clocking cb @(posedge REF_CLK_IN);
	endclocking
	default disable iff (SYS_RST_IN);
	// ==========
	// Properties
	a_servo_attr: assert property (
		quiet && SERVO_ON_IN && ATTR_C_VALID_IN |=> code == 17'h11B07)
		else $error("servo-on alarm code wrong");
	a_homing_cancel: assert property (
		(quiet && HOME_DETECT_IN && !HOME_RETURN_DONE_IN &&
		!HOMING_CANCEL_IN && HOMING_TYPE_IN inside {[8'h11:8'h1D]})
		##1 (quiet && !HOME_RETURN_DONE_IN && !HOMING_CANCEL_IN)
		##1 (quiet && HOMING_CANCEL_IN) |=> code == 17'h11B07)
		else $error("homing cancel alarm missing");
	a_dev_pulse: assert property (
		idle && (dp >= 64'sh3FFFFFFF || dp <= -64'sh3FFFFFFF)
		|=> code == 17'h11D02)
		else $error("pulse deviation alarm missing");
	a_dev_cmd: assert property (
		idle && (dc > 64'sh40000000 || dc < -64'sh40000000)
		|=> code == 17'h11D02)
		else $error("command deviation alarm missing");
	a_hold_first: assert property (
		ALARM_OUT && !SOFT_RESET_IN && !ALARM_CLEAR_IN && !WR_IN
		|=> $stable(code))
		else $error("held alarm code changed");
	a_clear_refused: assert property (
		ALARM_OUT && ALARM_MAIN_OUT != 8'h1C && !SOFT_RESET_IN && !WR_IN
		|=> $stable(code))
		else $error("alarm clear not refused");
	a_status_read: assert property (
		RD_IN && ADDR_IN == 8'h00
		|=> RD_DATA_OUT == {15'h0000, $past(code)})
		else $error("status read differs from alarm outputs");
	a_read_once: assert property (
		!RD_IN |=> RD_DATA_OUT == 32'h00000000)
		else $error("read data stood past one cycle");
endmodule // spa_chk
bind spa_alarm_checker spa_chk spa_chk_i (.*);
`default_nettype wire

// >>> test/spa_host.sv
// Host motion controller model that issues link commands.
`timescale 1ns/10ps
`default_nettype none
module spa_host
(
	// Clock
	input  wire logic       clk_in,
	// Link commands: servo-on, clear, soft reset, cancel, detect, done
	output var  logic [5:0] cmd_out,
	output var  logic       attr_c_out,
	output var  logic [7:0] htype_out
);
	// ==========
	// Commands
	initial
	begin
		cmd_out = 6'h00;
		attr_c_out = 1'b0;
		htype_out = 8'h00;
	end
	// Each command is a one-cycle pulse launched after an edge.
	task send(input logic [5:0] m);
	begin
		@(posedge clk_in);
		cmd_out <= m;
		@(posedge clk_in);
		cmd_out <= 6'h00;
	end
	endtask
	task mode(input logic a, input logic [7:0] t);
	begin
		@(posedge clk_in);
		attr_c_out <= a;
		htype_out <= t;
	end
	endtask
endmodule // spa_host
`default_nettype wire

// >>> test/testbench.sv
// Self-checking bench of the servo protection alarm checker.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	// ==========
	// Signals
	logic        clk, rst, wr, rd, regen, attr, alarm, absm;
	logic [7:0]  addr, htype, amain, asub, k;
	logic [31:0] wdata, rdata, d;
	logic [2:0]  trg;
	logic [5:0]  cmd;
	logic [63:0] pos, gear, devp, devc;
	integer      failures, samples_checked, n;
	wire         son, clr, sft, cnl, det, dne, atc, mtc, tod;
	assign {dne, det, cnl, sft, clr, son} = cmd;
	assign {tod, mtc, atc} = trg;
	spa_host spa_host_i (.clk_in(clk), .cmd_out(cmd), .attr_c_out(attr),
		.htype_out(htype));
	spa_alarm_checker #(.REGEN_WINDOW_CYC(16)) spa_alarm_checker_i (
		.REF_CLK_IN(clk), .SYS_RST_IN(rst), .ADDR_IN(addr),
		.WR_DATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RD_DATA_OUT(rdata),
		.SERVO_ON_IN(son), .ATTR_C_VALID_IN(attr),
		.ALARM_CLEAR_IN(clr), .SOFT_RESET_IN(sft),
		.HOMING_TYPE_IN(htype), .HOME_DETECT_IN(det),
		.HOME_RETURN_DONE_IN(dne), .HOMING_CANCEL_IN(cnl),
		.ABS_MODE_IN(absm), .ATTR_C_ENABLE_DONE_IN(atc),
		.MULTITURN_CLEAR_IN(mtc), .TOOL_OP_DONE_IN(tod),
		.ABS_POS_IN(pos), .GEAR_RATIO_IN(gear), .DEV_PULSE_IN(devp),
		.DEV_CMD_IN(devc), .REGEN_PULSE_IN(regen), .ALARM_OUT(alarm),
		.ALARM_MAIN_OUT(amain), .ALARM_SUB_OUT(asub));
	always #20 clk = ~clk;
	// ==========
	// Tasks
	task ck(input [31:0] s, input [31:0] e);
	begin
		samples_checked = samples_checked + 1;
		if (s !== e)
		begin
			failures = failures + 1;
			$display("mismatch %0t seen %h want %h", $time, s, e);
		end
	end
	endtask
	task finish_test;
	begin
		$display("checked %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	end
	endtask
	task wr_reg(input [7:0] a, input [31:0] v);
	begin
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	end
	endtask
	task rd_reg(input [7:0] a, output [31:0] v);
	begin
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	end
	endtask
	task chk(input [16:0] e);
	begin
		#1;
		ck({15'h0000, alarm, amain, asub}, {15'h0000, e});
		rd_reg(8'h00, d);
		ck(d, {15'h0000, e});
	end
	endtask
	task srst;
	begin
		spa_host_i.send(6'h04);
		chk(17'h00000);
	end
	endtask
	task dev(input [63:0] p, input [63:0] c, input [16:0] e);
	begin
		@(posedge clk);
		devp <= p;
		devc <= c;
		@(posedge clk);
		devp <= 64'h0;
		devc <= 64'h0;
		chk(e);
		srst;
	end
	endtask
	task init(input [63:0] p, input [63:0] g, input [2:0] t,
		input [16:0] e);
	begin
		@(posedge clk);
		pos <= p;
		gear <= g;
		trg <= t;
		@(posedge clk);
		trg <= 3'h0;
		pos <= 64'h0;
		gear <= 64'h1;
		chk(e);
		srst;
	end
	endtask
	task pin(input [7:0] a, input [23:0] v, input [7:0] s);
	begin
		wr_reg(a, {8'h00, v});
		rd_reg(a, d);
		ck(d, {8'h00, v});
		wr_reg(8'h04, 32'h00000004);
		chk({1'b1, 8'h21, s});
		spa_host_i.send(6'h02);
		chk({1'b1, 8'h21, s});
		wr_reg(a, (a == 8'h20) ? 32'h00000404 : (a == 8'h24) ?
			32'h00000505 : (a == 8'h28) ? 32'h00000606 : 32'h00000000);
		srst;
	end
	endtask
	task pulses(input integer c);
	begin
		@(posedge clk);
		regen <= 1'b1;
		repeat (c) @(posedge clk);
		regen <= 1'b0;
	end
	endtask
	// Mid-run reset with an overflowing position on the power-up edge.
	task rrst(input logic a, input [16:0] e);
	begin
		@(posedge clk);
		absm <= a;
		pos <= 64'h100000000;
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		pos <= 64'h0;
		chk(e);
	end
	endtask
	// ==========
	// Sequence
	initial
	begin
		clk = 1'b0;
		rst = 1'b1;
		absm = 1'b1;
		{wr, rd, regen, trg, addr, wdata} = 0;
		{pos, devp, devc} = 0;
		gear = 64'h1;
		failures = 0;
		samples_checked = 0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		chk(17'h00000);
		rd_reg(8'hF0, d);
		ck(d, 32'h00000000);
		wr_reg(8'h00, 32'hFFFFFFFF);
		chk(17'h00000);
		$display("test reset done");
		spa_host_i.mode(1'b1, 8'h00);
		spa_host_i.send(6'h01);
		chk(17'h11B07);
		spa_host_i.send(6'h02);
		chk(17'h11B07);
		wr_reg(8'h04, 32'h00000002);
		chk(17'h00000);
		spa_host_i.mode(1'b0, 8'h00);
		spa_host_i.send(6'h01);
		chk(17'h00000);
		for (k = 8'h00; k < 8'h04; k = k + 8'h01)
		begin
			spa_host_i.mode(1'b0, (k < 8'h02) ? 8'h10 + k : 8'h1B + k);
			spa_host_i.send(6'h10);
			spa_host_i.send(6'h08);
			chk((k == 8'h01 || k == 8'h02) ? 17'h11B07 : 17'h0);
			srst;
		end
		spa_host_i.mode(1'b0, 8'h11);
		spa_host_i.send(6'h10);
		spa_host_i.send(6'h20);
		spa_host_i.send(6'h08);
		chk(17'h00000);
		$display("test link done");
		rd_reg(8'h08, d);
		ck(d, 32'h00000000);
		pulses(20);
		repeat (20) @(posedge clk);
		chk(17'h00000);
		wr_reg(8'h08, 32'h00000003);
		rd_reg(8'h08, d);
		ck(d, 32'h00000003);
		pulses(3);
		repeat (20) @(posedge clk);
		chk(17'h00000);
		pulses(20);
		n = 0;
		while (alarm !== 1'b1 && n < 40)
		begin
			@(posedge clk);
			#1 n = n + 1;
		end
		if (n == 40)
		begin
			failures = failures + 1;
			$display("mismatch %0t alarm wait ran out", $time);
			finish_test;
		end
		chk(17'h11C00);
		spa_host_i.mode(1'b1, 8'h00);
		spa_host_i.send(6'h01);
		chk(17'h11C00);
		spa_host_i.mode(1'b0, 8'h00);
		repeat (40) @(posedge clk);
		wr_reg(8'h04, 32'h00000001);
		chk(17'h00000);
		$display("test regen done");
		dev(64'h3FFFFFFF, 64'h0, 17'h11D02);
		dev(64'h3FFFFFFE, 64'h0, 17'h00000);
		dev(64'hFFFFFFFFC0000001, 64'h0, 17'h11D02);
		dev(64'h0, 64'h40000000, 17'h00000);
		dev(64'h0, 64'h40000001, 17'h11D02);
		dev(64'h0, 64'hFFFFFFFFBFFFFFFF, 17'h11D02);
		init(64'h100000000, 64'h1, 3'h1, 17'h11D01);
		init(64'h0, 64'h100000000, 3'h2, 17'h11D01);
		init(64'hFFFFFFFF7FFFFFFF, 64'h1, 3'h4, 17'h11D01);
		init(64'hFFFFFFFF80000000, 64'hFFFFFFFF, 3'h4, 17'h0);
		rrst(1'b0, 17'h00000);
		rrst(1'b1, 17'h11D01);
		srst;
		$display("test overflow done");
		pin(8'h10, 24'h080000, 8'h00);
		pin(8'h2C, 24'h080000, 8'h01);
		pin(8'h14, 24'h000020, 8'h02);
		pin(8'h2C, 24'h000080, 8'h03);
		pin(8'h0C, 24'h000014, 8'h04);
		pin(8'h0C, 24'h140000, 8'h05);
		pin(8'h0C, 24'h001400, 8'h05);
		pin(8'h10, 24'h000404, 8'h08);
		pin(8'h20, 24'h000400, 8'h08);
		pin(8'h24, 24'h000303, 8'h08);
		pin(8'h28, 24'h000101, 8'h08);
		pin(8'h20, 24'h000202, 8'h08);
		$display("test pins done");
		finish_test;
	end
endmodule // testbench
`default_nettype wire
